// File: src/cld_pkg.sv
package cld_pkg;
    // Instruction field positions
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 11;
    localparam int RD_MSB = 10;
    localparam int RD_LSB = 8;
    localparam int BASE_MSB = 7;
    localparam int BASE_LSB = 5;
    localparam int INDEX_MSB = 4;
    localparam int INDEX_LSB = 2;
    localparam int OFFS_MSB = 4;
    localparam int COND_MSB = 12;
    localparam int COND_LSB = 9;
    localparam int BR_SHORT_MSB = 8;
    localparam int BR_LONG_MSB = 9;
    localparam int IMM_MSB = 7;

    // Major opcodes
    localparam logic [4:0] OPC_LOAD_BYTE_OFF = 5'h08;
    localparam logic [4:0] OPC_LOAD_WORD_OFF = 5'h09;
    localparam logic [4:0] OPC_STORE_BYTE_OFF = 5'h0A;
    localparam logic [4:0] OPC_STORE_WORD_OFF = 5'h0B;
    localparam logic [4:0] OPC_LOAD_BYTE_IDX = 5'h0C;
    localparam logic [4:0] OPC_LOAD_WORD_IDX = 5'h0D;
    localparam logic [4:0] OPC_STORE_BYTE_IDX = 5'h0E;
    localparam logic [4:0] OPC_STORE_WORD_IDX = 5'h0F;
    localparam logic [4:0] OPC_LOAD_LOW_IMM = 5'h1E;
    localparam logic [4:0] OPC_LOAD_HIGH_IMM = 5'h1F;
    localparam logic [1:0] OPC_LOGIC_TOP = 2'h2;
    localparam logic [2:0] OPC_BRANCH_TOP = 3'h1;
    localparam logic [3:0] COND_ALWAYS = 4'hE;

    // Index mode codes in the lowest two bits
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_PRE_DEC = 2'h2;
    localparam logic [1:0] MODE_FIELD = 2'h3;

    localparam logic [15:0] INDEX_STEP = 16'h0002;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Decoded operation class
    typedef enum logic [3:0] {
        CLD_OP_NONE,
        CLD_OP_LOAD_BYTE,
        CLD_OP_LOAD_WORD,
        CLD_OP_STORE_BYTE,
        CLD_OP_STORE_WORD,
        CLD_OP_FIELD_EXTRACT,
        CLD_OP_FIELD_INSERT,
        CLD_OP_FIELD_INSERT_INV,
        CLD_OP_FIELD_INSERT_XOR,
        CLD_OP_BRANCH,
        CLD_OP_LOGIC_IMM,
        CLD_OP_LOAD_LOW_IMM,
        CLD_OP_LOAD_HIGH_IMM
    } cld_op_t;

    // Addressing mode
    typedef enum logic [2:0] {
        CLD_AM_NONE,
        CLD_AM_BASE_OFFSET,
        CLD_AM_REG_INDEX,
        CLD_AM_POST_INC,
        CLD_AM_PRE_DEC
    } cld_am_t;
endpackage

// File: src/cld_decoder.sv
// Function
// [RULE_01] Word load writes sixteen bits, flags untouched
// [RULE_02] Post-increment adds two unless index is destination
// [RULE_03] Offset form: opcode, destination, base, five-bit offset
// [RULE_04] Low bits pick index mode or bit-field variant
// [RULE_05] Branch condition, nine/ten-bit offsets, byte immediates
// [RULE_06] Immediate word load is low then high byte
`timescale 1ns/1ps
module cld_decoder #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Instruction from fetch
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // Register file read values of base and index
    input wire logic [DATA_W-1:0] base_value,
    input wire logic [DATA_W-1:0] index_value,
    // Decoded instruction
    output logic dec_valid,
    output cld_pkg::cld_op_t dec_op,
    output cld_pkg::cld_am_t dec_mode,
    output logic [2:0] dest_reg,
    output logic [2:0] base_reg_field,
    output logic [2:0] index_reg_field,
    output logic [2:0] source_reg_field,
    output logic [4:0] short_offset_field,
    output logic [3:0] branch_cond,
    output logic signed [8:0] branch_offset_short,
    output logic signed [9:0] branch_offset_long,
    output logic [7:0] byte_immediate_field,
    output logic imm_high_byte,
    output logic [2:0] logic_func,
    // Data memory address and write-back control
    output logic [DATA_W-1:0] mem_addr,
    output logic index_wr_en,
    output logic [DATA_W-1:0] index_wr_value,
    output logic dest_wr_en,
    output logic dest_full_word,
    output logic flags_wr_en
);
    // Field slicing assumes a sixteen-bit word; refuse anything else at elaboration
    if (DATA_W != 16) begin : g_width_check
        $error("cld_decoder: DATA_W must be 16");
    end

    logic [4:0] opc;
    logic [1:0] low2;
    cld_pkg::cld_op_t op_c;
    cld_pkg::cld_am_t am_c;
    logic [DATA_W-1:0] addr_c;
    logic [DATA_W-1:0] idx_c;
    logic idx_we_c;
    logic dest_we_c;
    logic full_c;
    logic flags_c;

    logic dec_valid_q, dec_valid_d;
    cld_pkg::cld_op_t op_q, op_d;
    cld_pkg::cld_am_t am_q, am_d;
    logic [15:0] instr_q, instr_d;
    logic [DATA_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] idx_q, idx_d;
    logic idx_we_q, idx_we_d;
    logic dest_we_q, dest_we_d;
    logic full_q, full_d;
    logic flags_q, flags_d;

    assign opc = instr[cld_pkg::OPC_MSB:cld_pkg::OPC_LSB];
    assign low2 = instr[1:0];

    // Classify the instruction and work out address and write-back
    always_comb begin
        op_c = cld_pkg::CLD_OP_NONE;
        am_c = cld_pkg::CLD_AM_NONE;
        addr_c = cld_pkg::WORD_RESET;
        idx_c = index_value;
        idx_we_c = 1'b0;
        dest_we_c = 1'b0;
        full_c = 1'b0;
        flags_c = 1'b0;
        case (opc)
            cld_pkg::OPC_LOAD_BYTE_OFF, cld_pkg::OPC_LOAD_WORD_OFF,
            cld_pkg::OPC_STORE_BYTE_OFF, cld_pkg::OPC_STORE_WORD_OFF: begin
                am_c = cld_pkg::CLD_AM_BASE_OFFSET; // RULE_03
                addr_c = base_value + {11'h000, instr[cld_pkg::OFFS_MSB:0]}; // RULE_03
            end
            cld_pkg::OPC_LOAD_BYTE_IDX, cld_pkg::OPC_LOAD_WORD_IDX,
            cld_pkg::OPC_STORE_BYTE_IDX, cld_pkg::OPC_STORE_WORD_IDX: begin
                case (low2)
                    cld_pkg::MODE_PLAIN: begin
                        am_c = cld_pkg::CLD_AM_REG_INDEX; // RULE_04
                        addr_c = base_value + index_value;
                    end
                    cld_pkg::MODE_POST_INC: begin
                        am_c = cld_pkg::CLD_AM_POST_INC; // RULE_04
                        addr_c = base_value + index_value;
                        idx_c = index_value + cld_pkg::INDEX_STEP; // RULE_02
                        idx_we_c = 1'b1;
                    end
                    cld_pkg::MODE_PRE_DEC: begin
                        am_c = cld_pkg::CLD_AM_PRE_DEC; // RULE_04
                        idx_c = index_value - cld_pkg::INDEX_STEP;
                        addr_c = base_value + idx_c;
                        idx_we_c = 1'b1;
                    end
                    default: begin
                        am_c = cld_pkg::CLD_AM_NONE; // RULE_04
                    end
                endcase
            end
            default: begin
            end
        endcase
        // Operation class from the opcode
        case (opc)
            cld_pkg::OPC_LOAD_BYTE_OFF: op_c = cld_pkg::CLD_OP_LOAD_BYTE;
            cld_pkg::OPC_LOAD_WORD_OFF: op_c = cld_pkg::CLD_OP_LOAD_WORD;
            cld_pkg::OPC_STORE_BYTE_OFF: op_c = cld_pkg::CLD_OP_STORE_BYTE;
            cld_pkg::OPC_STORE_WORD_OFF: op_c = cld_pkg::CLD_OP_STORE_WORD;
            cld_pkg::OPC_LOAD_BYTE_IDX: op_c = (low2 == cld_pkg::MODE_FIELD) ?
                cld_pkg::CLD_OP_FIELD_EXTRACT : cld_pkg::CLD_OP_LOAD_BYTE; // RULE_04
            cld_pkg::OPC_LOAD_WORD_IDX: op_c = (low2 == cld_pkg::MODE_FIELD) ?
                cld_pkg::CLD_OP_FIELD_INSERT : cld_pkg::CLD_OP_LOAD_WORD; // RULE_04
            cld_pkg::OPC_STORE_BYTE_IDX: op_c = (low2 == cld_pkg::MODE_FIELD) ?
                cld_pkg::CLD_OP_FIELD_INSERT_INV : cld_pkg::CLD_OP_STORE_BYTE;
            cld_pkg::OPC_STORE_WORD_IDX: op_c = (low2 == cld_pkg::MODE_FIELD) ?
                cld_pkg::CLD_OP_FIELD_INSERT_XOR : cld_pkg::CLD_OP_STORE_WORD;
            cld_pkg::OPC_LOAD_LOW_IMM: op_c = cld_pkg::CLD_OP_LOAD_LOW_IMM; // RULE_06
            cld_pkg::OPC_LOAD_HIGH_IMM: op_c = cld_pkg::CLD_OP_LOAD_HIGH_IMM; // RULE_06
            default: begin
                if (opc[4:3] == cld_pkg::OPC_LOGIC_TOP) begin
                    op_c = cld_pkg::CLD_OP_LOGIC_IMM; // RULE_05
                end else if (opc[4:2] == cld_pkg::OPC_BRANCH_TOP) begin
                    op_c = cld_pkg::CLD_OP_BRANCH; // RULE_05
                end
            end
        endcase
        // Destination and flag write enables
        case (op_c)
            cld_pkg::CLD_OP_LOAD_WORD: begin
                dest_we_c = 1'b1;
                full_c = 1'b1; // RULE_01
                flags_c = 1'b0; // RULE_01
            end
            cld_pkg::CLD_OP_LOAD_BYTE, cld_pkg::CLD_OP_LOAD_LOW_IMM,
            cld_pkg::CLD_OP_LOAD_HIGH_IMM: begin
                dest_we_c = 1'b1; // RULE_06
            end
            cld_pkg::CLD_OP_FIELD_EXTRACT, cld_pkg::CLD_OP_FIELD_INSERT,
            cld_pkg::CLD_OP_FIELD_INSERT_INV, cld_pkg::CLD_OP_FIELD_INSERT_XOR: begin
                dest_we_c = 1'b1;
                full_c = 1'b1;
                flags_c = 1'b1;
            end
            cld_pkg::CLD_OP_LOGIC_IMM: begin
                // Bit-test forms set flags only and leave the destination alone
                dest_we_c = (opc[2:1] != 2'h1);
                flags_c = 1'b1;
            end
            default: begin
            end
        endcase
        // Loaded data wins over the post-increment index update on a shared register
        if ((op_c == cld_pkg::CLD_OP_LOAD_WORD || op_c == cld_pkg::CLD_OP_LOAD_BYTE)
            && am_c == cld_pkg::CLD_AM_POST_INC
            && instr[cld_pkg::INDEX_MSB:cld_pkg::INDEX_LSB]
            == instr[cld_pkg::RD_MSB:cld_pkg::RD_LSB]) begin
            idx_we_c = 1'b0; // RULE_02
        end
    end

    // Next-state: capture a new decode on each valid instruction
    always_comb begin
        dec_valid_d = instr_valid;
        op_d = op_q;
        am_d = am_q;
        instr_d = instr_q;
        addr_d = addr_q;
        idx_d = idx_q;
        idx_we_d = 1'b0;
        dest_we_d = 1'b0;
        full_d = full_q;
        flags_d = 1'b0;
        if (instr_valid) begin
            op_d = op_c;
            am_d = am_c;
            instr_d = instr;
            addr_d = addr_c;
            idx_d = idx_c;
            idx_we_d = idx_we_c;
            dest_we_d = dest_we_c;
            full_d = full_c;
            flags_d = flags_c;
        end
    end

    // Pipeline register; enables drop when no instruction arrives
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_valid_q <= 1'b0;
            op_q <= cld_pkg::CLD_OP_NONE;
            am_q <= cld_pkg::CLD_AM_NONE;
            instr_q <= cld_pkg::WORD_RESET;
            addr_q <= cld_pkg::WORD_RESET;
            idx_q <= cld_pkg::WORD_RESET;
            idx_we_q <= 1'b0;
            dest_we_q <= 1'b0;
            full_q <= 1'b0;
            flags_q <= 1'b0;
        end else begin
            dec_valid_q <= dec_valid_d;
            op_q <= op_d;
            am_q <= am_d;
            instr_q <= instr_d;
            addr_q <= addr_d;
            idx_q <= idx_d;
            idx_we_q <= idx_we_d;
            dest_we_q <= dest_we_d;
            full_q <= full_d;
            flags_q <= flags_d;
        end
    end

    // Field outputs sliced from the held instruction word
    assign dec_valid = dec_valid_q;
    assign dec_op = op_q;
    assign dec_mode = am_q;
    assign dest_reg = instr_q[cld_pkg::RD_MSB:cld_pkg::RD_LSB]; // RULE_03
    assign source_reg_field = instr_q[cld_pkg::RD_MSB:cld_pkg::RD_LSB];
    assign base_reg_field = instr_q[cld_pkg::BASE_MSB:cld_pkg::BASE_LSB]; // RULE_03
    assign index_reg_field = instr_q[cld_pkg::INDEX_MSB:cld_pkg::INDEX_LSB];
    assign short_offset_field = instr_q[cld_pkg::OFFS_MSB:0]; // RULE_03
    assign branch_cond = (op_q == cld_pkg::CLD_OP_BRANCH && instr_q[12:10] == 3'h7) ?
        cld_pkg::COND_ALWAYS : instr_q[cld_pkg::COND_MSB:cld_pkg::COND_LSB]; // RULE_05
    assign branch_offset_short = instr_q[cld_pkg::BR_SHORT_MSB:0]; // RULE_05
    assign branch_offset_long = instr_q[cld_pkg::BR_LONG_MSB:0]; // RULE_05
    assign byte_immediate_field = instr_q[cld_pkg::IMM_MSB:0]; // RULE_05
    assign imm_high_byte = instr_q[cld_pkg::OPC_LSB]; // RULE_05
    assign logic_func = instr_q[13:11];
    assign mem_addr = addr_q;
    assign index_wr_en = idx_we_q;
    assign index_wr_value = idx_q;
    assign dest_wr_en = dest_we_q;
    assign dest_full_word = full_q;
    assign flags_wr_en = flags_q;
endmodule

// File: test/cld_checker.sv
`timescale 1ns/1ps
module cld_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Decoder inputs
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] base_value,
    input wire logic [15:0] index_value,
    // Decoder outputs
    input wire cld_pkg::cld_am_t dec_mode,
    input wire logic [2:0] dest_reg,
    input wire logic [2:0] index_reg_field,
    input wire logic [4:0] short_offset_field,
    input wire logic signed [8:0] branch_offset_short,
    input wire logic signed [9:0] branch_offset_long,
    input wire logic [7:0] byte_immediate_field,
    input wire logic imm_high_byte,
    input wire logic [15:0] mem_addr,
    input wire logic index_wr_en,
    input wire logic [15:0] index_wr_value,
    input wire logic dest_wr_en,
    input wire logic dest_full_word,
    input wire logic flags_wr_en
);
    // All checks live in the core clock domain
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Each property ties a registered output to the instruction taken one edge before
    word_load_a: assert property (instr_valid && instr[15:11] == 5'h09
        |=> dest_wr_en && dest_full_word && !flags_wr_en) else $error("word load write-back");
    offset_addr_a: assert property (instr_valid && instr[15:11] == 5'h09
        |=> mem_addr == $past(base_value) + {11'h000, short_offset_field}
        && short_offset_field == $past(instr[4:0]) && dest_reg == $past(instr[10:8]))
        else $error("offset form address or fields");
    post_inc_a: assert property (instr_valid && instr[15:11] == 5'h0D
        && instr[1:0] == 2'h1
        |=> index_wr_en == (index_reg_field != dest_reg)
        && mem_addr == $past(base_value) + $past(index_value)) else $error("post increment");
    post_step_a: assert property (instr_valid && instr[15:11] == 5'h0D
        && instr[1:0] == 2'h1
        |=> !index_wr_en || index_wr_value == $past(index_value) + 16'h0002)
        else $error("post increment step");
    pre_dec_a: assert property (instr_valid && instr[15:11] == 5'h0D
        && instr[1:0] == 2'h2
        |=> index_wr_en && index_wr_value == $past(index_value) - 16'h0002
        && dec_mode == cld_pkg::CLD_AM_PRE_DEC) else $error("pre decrement");
    field_mode_a: assert property (instr_valid && instr[15:13] == 3'h3
        && instr[1:0] == 2'h3
        |=> dec_mode == cld_pkg::CLD_AM_NONE && !index_wr_en) else $error("bit-field mode");
    branch_offs_a: assert property (instr_valid && instr[15:13] == 3'h1
        |=> branch_offset_short == $past(instr[8:0]) && branch_offset_long == $past(instr[9:0]))
        else $error("branch offsets");
    imm_byte_a: assert property (instr_valid && instr[15:12] == 4'hF
        |=> byte_immediate_field == $past(instr[7:0]) && imm_high_byte == $past(instr[11])
        && !flags_wr_en) else $error("immediate byte load");
endmodule

// File: test/cld_regfile_model.sv
`timescale 1ns/1ps
module cld_regfile_model (
    // Instruction seen by the decoder
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // Register read values
    output logic [15:0] base_value,
    output logic [15:0] index_value
);
    logic [15:0] base_pick;
    logic [15:0] index_pick;

    // Each register holds a distinct value so a swapped field shows up in the address
    assign base_pick = {4'h1, 1'b0, instr[7:5], 8'h00};
    assign index_pick = {8'h20, 3'h0, instr[4:2], 2'h0};
    // Outside a valid cycle the ports show the inverse, so stale reads never match
    assign base_value = instr_valid ? base_pick : ~base_pick;
    assign index_value = instr_valid ? index_pick : ~index_pick;
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [15:0] base_value, index_value, mem_addr, index_wr_value;
    logic dec_valid, index_wr_en, dest_wr_en, dest_full_word, flags_wr_en, imm_high_byte;
    cld_pkg::cld_op_t dec_op;
    cld_pkg::cld_am_t dec_mode;
    logic [2:0] dest_reg, base_reg_field, index_reg_field, source_reg_field, logic_func;
    logic [4:0] short_offset_field;
    logic [3:0] branch_cond;
    logic signed [8:0] branch_offset_short;
    logic signed [9:0] branch_offset_long;
    logic [7:0] byte_immediate_field;
    int errors = 0;
    int compares = 0;

    // 200 MHz core clock
    always #2.5 ref_clk = ~ref_clk;

    // Design and register file model
    cld_decoder cld_decoder_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .base_value(base_value), .index_value(index_value), .dec_valid(dec_valid),
        .dec_op(dec_op), .dec_mode(dec_mode), .dest_reg(dest_reg),
        .base_reg_field(base_reg_field), .index_reg_field(index_reg_field),
        .source_reg_field(source_reg_field), .short_offset_field(short_offset_field),
        .branch_cond(branch_cond), .branch_offset_short(branch_offset_short),
        .branch_offset_long(branch_offset_long), .byte_immediate_field(byte_immediate_field),
        .imm_high_byte(imm_high_byte), .logic_func(logic_func), .mem_addr(mem_addr),
        .index_wr_en(index_wr_en), .index_wr_value(index_wr_value), .dest_wr_en(dest_wr_en),
        .dest_full_word(dest_full_word), .flags_wr_en(flags_wr_en)
    );
    cld_regfile_model cld_regfile_model_i (
        .instr_valid(instr_valid), .instr(instr), .base_value(base_value),
        .index_value(index_value)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One instruction, then outputs are looked at after the answering edge
    task automatic issue(input logic [15:0] ins);
        @(posedge ref_clk) #1;
        instr_valid = 1'b1;
        instr = ins;
        @(posedge ref_clk) #1;
        instr_valid = 1'b0;
    endtask

    function automatic logic [15:0] base_of(input logic [2:0] n);
        return {4'h1, 1'b0, n, 8'h00};
    endfunction

    function automatic logic [15:0] index_of(input logic [2:0] n);
        return {8'h20, 3'h0, n, 2'h0};
    endfunction

    task automatic t_load_off;
        issue({5'h09, 3'h3, 3'h5, 5'h1F});
        chk(dec_op, cld_pkg::CLD_OP_LOAD_WORD);
        chk({dest_wr_en, dest_full_word, flags_wr_en}, 3'h6);
        chk(dec_valid, 1'b1);
        chk(mem_addr, base_of(3'h5) + 16'h001F);
        chk({dest_reg, base_reg_field, short_offset_field}, {3'h3, 3'h5, 5'h1F});
        // With no new instruction the pulses must drop after one cycle
        @(posedge ref_clk) #1;
        chk({dec_valid, dest_wr_en}, 2'h0);
        issue({5'h0B, 3'h2, 3'h4, 5'h06});
        chk(dec_op, cld_pkg::CLD_OP_STORE_WORD);
        chk({dest_wr_en, dest_full_word, flags_wr_en}, 3'h0);
        chk(mem_addr, base_of(3'h4) + 16'h0006);
        chk(source_reg_field, 3'h2);
        $display("load offset test done");
    endtask

    task automatic t_index;
        logic [2:0] rd;
        for (int k = 0; k < 2; k++) begin
            rd = k ? 3'h1 : 3'h5;
            issue({5'h0D, rd, 3'h2, 3'h1, 2'h1});
            chk(dec_mode, cld_pkg::CLD_AM_POST_INC);
            chk(index_wr_en, rd != 3'h1);
            chk(mem_addr, base_of(3'h2) + index_of(3'h1));
            if (k == 0) chk(index_wr_value, index_of(3'h1) + 16'h0002);
        end
        issue({5'h0D, 3'h4, 3'h6, 3'h7, 2'h2});
        chk(dec_mode, cld_pkg::CLD_AM_PRE_DEC);
        chk(mem_addr, base_of(3'h6) + index_of(3'h7) - 16'h0002);
        chk(index_wr_value, index_of(3'h7) - 16'h0002);
        // Byte load with index equal to destination keeps the loaded data
        issue({5'h0C, 3'h3, 3'h2, 3'h3, 2'h1});
        chk({index_wr_en, dest_wr_en, dest_full_word}, 3'h2);
        issue({5'h0E, 3'h2, 3'h1, 3'h3, 2'h0});
        chk(dec_op, cld_pkg::CLD_OP_STORE_BYTE);
        chk(dec_mode, cld_pkg::CLD_AM_REG_INDEX);
        chk({dest_wr_en, index_wr_en, source_reg_field}, {2'h0, 3'h2});
        for (int k = 0; k < 4; k++) begin
            issue({3'h3, 2'(k), 3'h1, 3'h2, 3'h3, 2'h3});
            chk(dec_op, 16'(cld_pkg::CLD_OP_FIELD_EXTRACT) + 16'(k));
            chk(dec_mode, cld_pkg::CLD_AM_NONE);
        end
        $display("indexed test done");
    endtask

    task automatic t_branch;
        for (int c = 0; c < 14; c++) begin
            issue({3'h1, 4'(c), 9'h1A5});
            chk(dec_op, cld_pkg::CLD_OP_BRANCH);
            chk({branch_cond, 3'h0, branch_offset_short}, {4'(c), 3'h0, 9'h1A5});
        end
        issue({6'h0F, 10'h2C3});
        chk({branch_cond, 2'h0, branch_offset_long}, {4'hE, 2'h0, 10'h2C3});
        $display("branch test done");
    endtask

    task automatic t_logic;
        for (int k = 0; k < 8; k++) begin
            issue({2'h2, 3'(k), 3'h2, 8'h5A});
            chk(dec_op, cld_pkg::CLD_OP_LOGIC_IMM);
            chk({logic_func, imm_high_byte}, {3'(k), k[0]});
            chk(byte_immediate_field, 8'h5A);
            // Bit-test forms only write flags
            chk({dest_reg, dest_wr_en, flags_wr_en}, {3'h2, k[2:1] != 2'h1, 1'b1});
        end
        issue(16'hC123);
        chk(dec_op, cld_pkg::CLD_OP_NONE);
        chk({dest_wr_en, flags_wr_en, index_wr_en}, 3'h0);
        issue({5'h1E, 3'h6, 8'h34});
        chk(dec_op, cld_pkg::CLD_OP_LOAD_LOW_IMM);
        chk({dest_wr_en, flags_wr_en, imm_high_byte, byte_immediate_field}, {3'h4, 8'h34});
        issue({5'h1F, 3'h6, 8'h12});
        chk(dec_op, cld_pkg::CLD_OP_LOAD_HIGH_IMM);
        chk({dest_wr_en, flags_wr_en, imm_high_byte, dest_reg}, {3'h5, 3'h6});
        chk(byte_immediate_field, 8'h12);
        $display("immediate test done");
    endtask

    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_load_off;
        t_index;
        t_branch;
        t_logic;
        final_report;
    end

    // Tests need well under 1 us; a hang ends here
    initial begin
        #20000;
        errors++;
        final_report;
    end
endmodule

bind cld_decoder cld_checker cld_checker_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .base_value(base_value), .index_value(index_value), .dec_mode(dec_mode),
    .dest_reg(dest_reg), .index_reg_field(index_reg_field),
    .short_offset_field(short_offset_field), .branch_offset_short(branch_offset_short),
    .branch_offset_long(branch_offset_long), .byte_immediate_field(byte_immediate_field),
    .imm_high_byte(imm_high_byte), .mem_addr(mem_addr), .index_wr_en(index_wr_en),
    .index_wr_value(index_wr_value), .dest_wr_en(dest_wr_en),
    .dest_full_word(dest_full_word), .flags_wr_en(flags_wr_en)
);
